// *** rtl/serial_status_pkg.sv ***
package serial_status_pkg;

   // register byte addresses on the apb bus
   localparam logic [7:0] ADDR_STATUS     = 8'h00;
   localparam logic [7:0] ADDR_CONTROL    = 8'h04;
   localparam logic [7:0] ADDR_RX_BUFFER  = 8'h08;
   localparam logic [7:0] ADDR_TX_BUFFER  = 8'h0C;

   // serial_status field positions
   localparam int BIT_TX_EMPTY     = 7;
   localparam int BIT_RX_FULL      = 6;
   localparam int BIT_OVERRUN      = 5;
   localparam int BIT_FRAMING      = 4;
   localparam int BIT_PARITY       = 3;
   localparam int BIT_TX_DONE      = 2;
   localparam int BIT_RX_MULTIPROC = 1;
   localparam int BIT_TX_MULTIPROC = 0;

   // control field positions
   localparam int BIT_RX_ENABLE    = 0;
   localparam int BIT_TX_ENABLE    = 1;
   localparam int BIT_SYNC_MODE    = 2;
   localparam int BIT_MULTIPROC    = 3;
   localparam int BIT_PARITY_ODD   = 4;
   localparam int BIT_PARITY_EN    = 5;
   localparam int BIT_TWO_STOP     = 6;
   localparam int BIT_STANDBY      = 7;

   // reset values
   localparam logic [7:0] STATUS_RESET  = 8'h84;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] BUFFER_RESET  = 8'h00;

   // armed index order: tx_empty, rx_full, overrun, framing, parity
   localparam int ARM_TX_EMPTY = 4;
   localparam int ARM_RX_FULL  = 3;
   localparam int ARM_OVERRUN  = 2;
   localparam int ARM_FRAMING  = 1;
   localparam int ARM_PARITY   = 0;

   typedef struct packed {
      logic        tx_buffer_empty_flag;
      logic        rx_buffer_full_flag;
      logic        overrun_flag;
      logic        framing_error_flag;
      logic        parity_error_flag;
      logic        tx_done_flag;
      logic        rx_multiproc_bit;
      logic        tx_multiproc_bit;
      logic [4:0]  armed;
      logic [7:0]  control;
      logic [7:0]  rx_buffer;
      logic [7:0]  tx_buffer;
      logic        tx_busy;
      logic        tx_mp_out;
      logic        rx_halt;
      logic        tx_halt;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } state_type;

endpackage : serial_status_pkg

// *** rtl/serial_status_flags.sv ***
`timescale 1ns/100ps
`default_nettype none

// Operation
// (RQ1) rx end while buffer full sets overrun flag
// (RQ2) overrun clears on reset, standby, or read-one then write-zero
// (RQ3) dropping rx enable leaves overrun, framing, parity flags unchanged
// (RQ4) on overrun buffer keeps old character, new one dropped
// (RQ5) any error flag halts reception; sync mode halts transmission too
// (RQ6) async: first stop bit zero sets framing flag
// (RQ7) with two stop bits only the first is checked
// (RQ8) framing error loads buffer but leaves buffer-full clear
// (RQ9) framing flag clears on reset, standby, or read-one then write-zero
// (RQ10) parity mismatch against odd/even setting sets parity flag
// (RQ11) parity error loads buffer but leaves buffer-full clear
// (RQ12) parity flag clears on reset, standby, or read-one then write-zero
// (RQ13) last bit sent with buffer empty sets tx done; reset/standby set it
// (RQ14) clearing tx enable sets tx done
// (RQ15) clearing buffer-empty by read-one write-zero clears tx done
// (RQ16) dma write into tx buffer clears tx done
// (RQ17) tx done is read-only
// (RQ18) async multiproc: received multiproc bit captured, read-only, resets zero
// (RQ19) dropping rx enable keeps captured multiproc bit
// (RQ20) async multiproc: written tx multiproc bit appended to character
// (RQ21) tx multiproc bit ignored in sync, non-multiproc, or idle
// (RQ22) software cannot write one into the five clearable flags
// (RQ23) zero write clears a flag only after it was read as one
// (RQ24) clean reception loads buffer and sets buffer-full
module serial_status_flags (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_done,
   input  wire logic [7:0]  rx_data,
   input  wire logic [1:0]  rx_stop_bits,
   input  wire logic        rx_parity_bit,
   input  wire logic        rx_mp_bit,
   input  wire logic        tx_load,
   input  wire logic        tx_last_bit,
   input  wire logic        dma_rx_read,
   input  wire logic        dma_tx_write,
   input  wire logic [7:0]  dma_tx_data,
   output logic      [7:0]  rx_buffer_data,
   output logic      [7:0]  tx_buffer_data,
   output logic             tx_mp_out,
   output logic             rx_halt,
   output logic             tx_halt,
   output logic      [7:0]  control_out
);

   serial_status_pkg::state_type state_reg;
   serial_status_pkg::state_type state_next;

   logic [7:0] status_view;
   logic       tx_en_fall;
   logic       complete;
   logic       wr_status;
   logic       wr_control;
   logic       async_mode;
   logic       mp_async;
   logic       stop_err;
   logic       par_err;
   logic       rx_take;

   always_comb begin
      status_view = {state_reg.tx_buffer_empty_flag, state_reg.rx_buffer_full_flag,
                     state_reg.overrun_flag, state_reg.framing_error_flag,
                     state_reg.parity_error_flag, state_reg.tx_done_flag,
                     state_reg.rx_multiproc_bit, state_reg.tx_multiproc_bit};
      complete    = psel & penable & state_reg.pready;
      wr_status   = complete & pwrite & (paddr == serial_status_pkg::ADDR_STATUS);
      wr_control  = complete & pwrite & (paddr == serial_status_pkg::ADDR_CONTROL);
      tx_en_fall  = wr_control & state_reg.control[serial_status_pkg::BIT_TX_ENABLE] &
                    ~pwdata[serial_status_pkg::BIT_TX_ENABLE];
      async_mode  = ~state_reg.control[serial_status_pkg::BIT_SYNC_MODE];
      mp_async    = async_mode & state_reg.control[serial_status_pkg::BIT_MULTIPROC];
      // (RQ7) first stop only
      stop_err    = async_mode & ~rx_stop_bits[0];
      // (RQ10) parity against setting
      par_err     = async_mode & state_reg.control[serial_status_pkg::BIT_PARITY_EN] &
                    ((^{rx_data, rx_parity_bit}) ^ state_reg.control[serial_status_pkg::BIT_PARITY_ODD]);
      // (RQ5) halted while error flagged
      rx_take     = rx_done & state_reg.control[serial_status_pkg::BIT_RX_ENABLE] & ~state_reg.rx_halt;

      state_next         = state_reg;
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;

      // one wait state: data registered so prdata comes from a flop
      if (psel & penable & ~state_reg.pready) begin
         state_next.pready  = 1'b1;
         state_next.pslverr = 1'b0;
         case (paddr)
            serial_status_pkg::ADDR_STATUS:    state_next.prdata = {24'h00_0000, status_view};
            serial_status_pkg::ADDR_CONTROL:   state_next.prdata = {24'h00_0000, state_reg.control};
            serial_status_pkg::ADDR_RX_BUFFER: state_next.prdata = {24'h00_0000, state_reg.rx_buffer};
            serial_status_pkg::ADDR_TX_BUFFER: state_next.prdata = {24'h00_0000, state_reg.tx_buffer};
            default: begin
               state_next.prdata  = 32'h0000_0000;
               state_next.pslverr = 1'b1;
            end
         endcase
      end

      // arm from the value the reader actually saw
      if (complete & ~pwrite & (paddr == serial_status_pkg::ADDR_STATUS)) begin
         state_next.armed = state_reg.armed | state_reg.prdata[7:3];
      end

      if (wr_status) begin
         // (RQ22) ones ignored, only zeros clear
         // (RQ23) clear only when armed
         // (RQ2) overrun software clear
         if (~pwdata[serial_status_pkg::BIT_OVERRUN] & state_reg.armed[serial_status_pkg::ARM_OVERRUN]) begin
            state_next.overrun_flag = 1'b0;
         end
         // (RQ9) framing software clear
         if (~pwdata[serial_status_pkg::BIT_FRAMING] & state_reg.armed[serial_status_pkg::ARM_FRAMING]) begin
            state_next.framing_error_flag = 1'b0;
         end
         // (RQ12) parity software clear
         if (~pwdata[serial_status_pkg::BIT_PARITY] & state_reg.armed[serial_status_pkg::ARM_PARITY]) begin
            state_next.parity_error_flag = 1'b0;
         end
         if (~pwdata[serial_status_pkg::BIT_RX_FULL] & state_reg.armed[serial_status_pkg::ARM_RX_FULL]) begin
            state_next.rx_buffer_full_flag = 1'b0;
         end
         if (~pwdata[serial_status_pkg::BIT_TX_EMPTY] & state_reg.armed[serial_status_pkg::ARM_TX_EMPTY]) begin
            state_next.tx_buffer_empty_flag = 1'b0;
            // (RQ15) tx done follows empty clear
            state_next.tx_done_flag = 1'b0;
         end
         // (RQ17) tx done and rx multiproc not writable
         state_next.tx_multiproc_bit = pwdata[serial_status_pkg::BIT_TX_MULTIPROC];
      end

      if (wr_control) begin
         state_next.control = pwdata[7:0];
         // (RQ3) rx enable change leaves error flags alone
         // (RQ19) rx multiproc kept too
      end

      if (complete & pwrite & (paddr == serial_status_pkg::ADDR_TX_BUFFER)) begin
         state_next.tx_buffer = pwdata[7:0];
      end

      if (dma_rx_read) begin
         state_next.rx_buffer_full_flag = 1'b0;
      end
      if (dma_tx_write) begin
         state_next.tx_buffer            = dma_tx_data;
         state_next.tx_buffer_empty_flag = 1'b0;
         // (RQ16) dma write clears done
         state_next.tx_done_flag         = 1'b0;
      end

      // hardware sets come last so a same-cycle clear loses
      if (tx_load) begin
         state_next.tx_buffer_empty_flag = 1'b1;
         state_next.tx_busy              = 1'b1;
      end
      if (tx_last_bit & state_reg.tx_buffer_empty_flag) begin
         // (RQ13) last bit with empty buffer
         state_next.tx_done_flag = 1'b1;
         state_next.tx_busy      = 1'b0;
      end
      // (RQ14) tx enable falling sets done, after the dma clear so the set wins
      if (tx_en_fall) begin
         state_next.tx_buffer_empty_flag = 1'b1;
         state_next.tx_done_flag         = 1'b1;
      end

      if (rx_take) begin
         if (state_reg.rx_buffer_full_flag) begin
            // (RQ1) overrun on full buffer
            state_next.overrun_flag = 1'b1;
            // (RQ4) old character kept, new dropped
         end else begin
            state_next.rx_buffer = rx_data;
            // (RQ18) capture multiproc bit
            if (mp_async) begin
               state_next.rx_multiproc_bit = rx_mp_bit;
            end
            // (RQ6) stop bit zero flags framing
            if (stop_err) begin
               state_next.framing_error_flag = 1'b1;
            end
            if (par_err) begin
               state_next.parity_error_flag = 1'b1;
            end
            // (RQ8) (RQ11) errors skip buffer-full
            // (RQ24) clean character sets buffer-full
            if (~stop_err & ~par_err) begin
               state_next.rx_buffer_full_flag = 1'b1;
            end
         end
      end

      // standby holds the status at its reset image
      if (state_reg.control[serial_status_pkg::BIT_STANDBY]) begin
         {state_next.tx_buffer_empty_flag, state_next.rx_buffer_full_flag,
          state_next.overrun_flag, state_next.framing_error_flag,
          state_next.parity_error_flag, state_next.tx_done_flag,
          state_next.rx_multiproc_bit, state_next.tx_multiproc_bit} = serial_status_pkg::STATUS_RESET;
         state_next.tx_busy = 1'b0;
      end

      // an arm dies with its flag, so a stale read cannot clear a later event
      state_next.armed = state_next.armed & {state_next.tx_buffer_empty_flag, state_next.rx_buffer_full_flag,
                                             state_next.overrun_flag, state_next.framing_error_flag,
                                             state_next.parity_error_flag};

      // (RQ20) (RQ21) bit appended only when async multiproc and sending
      state_next.tx_mp_out = state_next.tx_busy & ~state_next.control[serial_status_pkg::BIT_SYNC_MODE] &
                             state_next.control[serial_status_pkg::BIT_MULTIPROC] & state_next.tx_multiproc_bit;
      // (RQ5) halt from error flags
      state_next.rx_halt = state_next.overrun_flag | state_next.framing_error_flag | state_next.parity_error_flag;
      state_next.tx_halt = state_next.rx_halt & state_next.control[serial_status_pkg::BIT_SYNC_MODE];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.tx_buffer_empty_flag <= 1'b1;
         state_reg.rx_buffer_full_flag  <= 1'b0;
         state_reg.overrun_flag         <= 1'b0;
         state_reg.framing_error_flag   <= 1'b0;
         state_reg.parity_error_flag    <= 1'b0;
         state_reg.tx_done_flag         <= 1'b1;
         state_reg.rx_multiproc_bit     <= 1'b0;
         state_reg.tx_multiproc_bit     <= 1'b0;
         state_reg.armed                <= 5'h00;
         state_reg.control              <= serial_status_pkg::CONTROL_RESET;
         state_reg.rx_buffer            <= serial_status_pkg::BUFFER_RESET;
         state_reg.tx_buffer            <= serial_status_pkg::BUFFER_RESET;
         state_reg.tx_busy              <= 1'b0;
         state_reg.tx_mp_out            <= 1'b0;
         state_reg.rx_halt              <= 1'b0;
         state_reg.tx_halt              <= 1'b0;
         state_reg.pready               <= 1'b0;
         state_reg.pslverr              <= 1'b0;
         state_reg.prdata               <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata         = state_reg.prdata;
   assign pready         = state_reg.pready;
   assign pslverr        = state_reg.pslverr;
   assign rx_buffer_data = state_reg.rx_buffer;
   assign tx_buffer_data = state_reg.tx_buffer;
   assign tx_mp_out      = state_reg.tx_mp_out;
   assign rx_halt        = state_reg.rx_halt;
   assign tx_halt        = state_reg.tx_halt;
   assign control_out    = state_reg.control;

endmodule : serial_status_flags

`default_nettype wire

// *** tb/serial_status_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_status_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rx_done,
   input wire logic [7:0]  rx_data,
   input wire logic [1:0]  rx_stop_bits,
   input wire logic        rx_parity_bit,
   input wire logic [7:0]  rx_buffer_data,
   input wire logic        tx_mp_out,
   input wire logic        rx_halt,
   input wire logic        tx_halt,
   input wire logic [7:0]  control_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic take;
   logic mapped;
   // standby pins status, so no halt is expected there
   assign take   = rx_done && control_out[0] && !control_out[7] && !rx_halt;
   assign mapped = paddr[1:0] == 2'b00 && paddr[7:4] == 4'h0;
   a_halt_blocks_rx: assert property (rx_done && !take |=> $stable(rx_buffer_data)) else $error("buffer moved");
   a_rx_loads_buf: assert property (take |=> rx_buffer_data == $past(rx_data)
      || (rx_halt && $stable(rx_buffer_data))) else $error("buffer not loaded");
   a_stop_zero_halts: assert property (take && !control_out[2] && !rx_stop_bits[0] |=> rx_halt)
      else $error("framing not flagged");
   a_parity_err_halts: assert property (take && !control_out[2] && control_out[5]
      && ((^{rx_data, rx_parity_bit}) != control_out[4]) |=> rx_halt) else $error("parity not flagged");
   a_tx_halt_sync: assert property ($past(rx_halt) && rx_halt && $stable(control_out)
      |-> tx_halt == control_out[2]) else $error("tx halt wrong");
   a_mp_out_mode: assert property (tx_mp_out |-> (control_out[3] && !control_out[2])
      || $past(control_out[3] && !control_out[2])) else $error("mp bit outside format");
   a_pready_once: assert property (pready |=> !pready) else $error("pready held");
   a_answer_time: assert property (psel && !penable |-> ##[1:3] pready) else $error("no answer");
   a_err_unmapped: assert property (pslverr == (pready && !mapped)) else $error("pslverr wrong");
   a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits");
   a_standby_status: assert property (pready && !pwrite && paddr == 8'h00 && control_out[7]
      && $past(control_out[7]) |-> prdata[7:0] == 8'h84) else $error("standby status");
endmodule : serial_status_props
bind serial_status_flags serial_status_props u_serial_status_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rx_done(rx_done), .rx_data(rx_data), .rx_stop_bits(rx_stop_bits), .rx_parity_bit(rx_parity_bit),
   .rx_buffer_data(rx_buffer_data), .tx_mp_out(tx_mp_out), .rx_halt(rx_halt), .tx_halt(tx_halt),
   .control_out(control_out));
`default_nettype wire

// *** tb/serial_far_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_far_end (
   input  wire logic  pclk,
   output logic       rx_done,
   output logic [7:0] rx_data,
   output logic [1:0] rx_stop_bits,
   output logic       rx_parity_bit,
   output logic       rx_mp_bit,
   output logic       tx_load,
   output logic       tx_last_bit
);
   initial begin
      {rx_done, tx_load, tx_last_bit} = 3'b000;
      {rx_data, rx_stop_bits, rx_parity_bit, rx_mp_bit} = 12'h000;
   end
   task automatic send_char(input logic [7:0] d, input logic [1:0] stop, input logic par, input logic mp);
      @(posedge pclk);
      rx_done <= 1'b1;
      {rx_data, rx_stop_bits, rx_parity_bit, rx_mp_bit} <= {d, stop, par, mp};
      @(posedge pclk);
      rx_done <= 1'b0;
      // inverted after the pulse so stale fields never look valid
      {rx_data, rx_stop_bits, rx_parity_bit, rx_mp_bit} <= ~{d, stop, par, mp};
   endtask : send_char
   task automatic pulse_tx(input logic last);
      @(posedge pclk);
      {tx_load, tx_last_bit} <= {!last, last};
      @(posedge pclk);
      {tx_load, tx_last_bit} <= 2'b00;
   endtask : pulse_tx
endmodule : serial_far_end
`default_nettype wire

// *** tb/tb_serial_status_flags.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_serial_status_flags;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [7:0] paddr = 8'h00, dma_tx_data = 8'h00, rx_buffer_data, tx_buffer_data, control_out, rx_data;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q, seed = 32'h1a01_09d2;
   logic dma_rx_read = 1'b0, dma_tx_write = 1'b0, tx_mp_out, rx_halt, tx_halt;
   logic rx_done, rx_parity_bit, rx_mp_bit, tx_load, tx_last_bit;
   logic [1:0] rx_stop_bits;
   int failures = 0, cmp_count = 0;
   always #10 pclk = ~pclk;
   serial_status_flags u_serial_status_flags (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_done(rx_done), .rx_data(rx_data), .rx_stop_bits(rx_stop_bits), .rx_parity_bit(rx_parity_bit),
      .rx_mp_bit(rx_mp_bit), .tx_load(tx_load), .tx_last_bit(tx_last_bit), .dma_rx_read(dma_rx_read),
      .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data), .rx_buffer_data(rx_buffer_data),
      .tx_buffer_data(tx_buffer_data), .tx_mp_out(tx_mp_out), .rx_halt(rx_halt), .tx_halt(tx_halt),
      .control_out(control_out));
   serial_far_end u_serial_far_end (.pclk(pclk), .rx_done(rx_done), .rx_data(rx_data), .rx_stop_bits(rx_stop_bits),
      .rx_parity_bit(rx_parity_bit), .rx_mp_bit(rx_mp_bit), .tx_load(tx_load), .tx_last_bit(tx_last_bit));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic good_par(input logic [7:0] d, input logic odd);
      return (^d) ^ odd;
   endfunction : good_par
   // pready and read data are taken at the rising edge that completes the access
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) failures++;
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic rs;
      apb(1'b0, serial_status_pkg::ADDR_STATUS, 8'h00);
   endtask : rs
   task automatic ws(input logic [7:0] d);
      apb(1'b1, serial_status_pkg::ADDR_STATUS, d);
   endtask : ws
   task automatic wc(input logic [7:0] d);
      apb(1'b1, serial_status_pkg::ADDR_CONTROL, d);
   endtask : wc
   task automatic dma(input logic rd, input logic [7:0] d);
      @(posedge pclk);
      {dma_rx_read, dma_tx_write, dma_tx_data} <= {rd, !rd, d};
      @(posedge pclk);
      {dma_rx_read, dma_tx_write} <= 2'b00;
   endtask : dma
   task automatic settle;
      repeat (2) @(negedge pclk);
   endtask : settle
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   // whole run is near three hundred cycles; ten thousand means a hang
   initial begin
      #200000;
      failures++;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rs;
      `CHK("status reset", serial_status_pkg::STATUS_RESET, q[7:0])
      apb(1'b0, serial_status_pkg::ADDR_CONTROL, 8'h00);
      `CHK("control reset", serial_status_pkg::CONTROL_RESET, q[7:0])
      ws(8'h80);
      rs;
      `CHK("tx done write", 8'h84, q[7:0])
      ws(8'hFF);
      rs;
      `CHK("write ones", 8'h85, q[7:0])
      ws(8'h00);
      rs;
      `CHK("empty clear", 8'h00, q[7:0])
      wc(8'h02);
      u_serial_far_end.pulse_tx(1'b0);
      u_serial_far_end.pulse_tx(1'b1);
      rs;
      `CHK("tx end", 1'b1, q[2])
      seed = lfsr(seed);
      dma(1'b0, seed[7:0]);
      rs;
      `CHK("dma write", 2'b00, {q[7], q[2]})
      `CHK("tx buffer", seed[7:0], tx_buffer_data)
      wc(8'h00);
      rs;
      `CHK("tx disable", 1'b1, q[2])
      wc(8'h0A);
      ws(8'hF9);
      u_serial_far_end.pulse_tx(1'b0);
      settle;
      `CHK("mp out", 1'b1, tx_mp_out)
      wc(8'h0E);
      settle;
      `CHK("mp sync", 1'b0, tx_mp_out)
      u_serial_far_end.pulse_tx(1'b1);
      wc(8'h01);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         u_serial_far_end.send_char(seed[7:0], seed[9:8] | 2'b01, seed[10], seed[11]);
         settle;
         `CHK("rx buffer", seed[7:0], rx_buffer_data)
         rs;
         `CHK("rx full", 4'b1000, q[6:3])
         dma(1'b1, 8'h00);
      end
      u_serial_far_end.send_char(8'h5A, 2'b11, 1'b0, 1'b0);
      u_serial_far_end.send_char(8'hA5, 2'b11, 1'b0, 1'b0);
      u_serial_far_end.send_char(8'hC3, 2'b11, 1'b0, 1'b0);
      settle;
      `CHK("overrun keep", 8'h5A, rx_buffer_data)
      `CHK("overrun halt", 1'b1, rx_halt)
      wc(8'h00);
      ws(8'h00);
      rs;
      `CHK("clear unarmed", 1'b1, q[5])
      ws(8'h00);
      rs;
      `CHK("overrun clear", 2'b00, {q[5], rx_halt})
      wc(8'h01);
      u_serial_far_end.send_char(8'h3C, 2'b10, 1'b0, 1'b0);
      rs;
      `CHK("framing", 4'b0010, q[6:3])
      `CHK("framing data", 8'h3C, rx_buffer_data)
      ws(8'h00);
      rs;
      `CHK("framing clear", 1'b0, q[4])
      u_serial_far_end.send_char(8'hC3, 2'b01, 1'b0, 1'b0);
      rs;
      `CHK("second stop", 4'b1000, q[6:3])
      dma(1'b1, 8'h00);
      for (int k = 0; k < 2; k++) begin
         wc(8'h21 | {3'b000, k[0], 4'h0});
         u_serial_far_end.send_char(8'h96, 2'b11, good_par(8'h96, k[0]), 1'b0);
         rs;
         `CHK("parity good", 4'b1000, q[6:3])
         dma(1'b1, 8'h00);
         u_serial_far_end.send_char(8'h4B, 2'b11, !good_par(8'h4B, k[0]), 1'b0);
         rs;
         `CHK("parity bad", 4'b0001, q[6:3])
         `CHK("parity data", 8'h4B, rx_buffer_data)
         wc(8'h25 | {3'b000, k[0], 4'h0});
         settle;
         `CHK("sync tx halt", 1'b1, tx_halt)
         ws(8'h00);
         rs;
         `CHK("parity clear", 1'b0, q[3])
      end
      wc(8'h09);
      u_serial_far_end.send_char(8'h11, 2'b11, 1'b0, 1'b1);
      rs;
      `CHK("rx mp", 1'b1, q[1])
      wc(8'h08);
      rs;
      `CHK("rx mp kept", 1'b1, q[1])
      wc(8'h80);
      rs;
      `CHK("standby", 8'h84, q[7:0])
      apb(1'b0, 8'h10, 8'h00);
      `CHK("unmapped", 9'h100, {e, q[7:0]})
      finish_test;
   end
endmodule : tb_serial_status_flags
`default_nettype wire
